// [common/wdtu_pkg.sv]
// Constants and types for the watchdog timer unit.
// Assumes an 8-bit special-function register port on the processor core.
package wdtu_pkg;

    // Control register location and field positions
    localparam logic [7:0] WDTU_CTRL_ADDR   = 8'hC0;
    localparam int         WDTU_UNLOCK_BIT  = 0;
    localparam int         WDTU_ARM_BIT     = 1;
    localparam int         WDTU_STATUS_BIT  = 2;
    localparam int         WDTU_RESP_BIT    = 3;
    localparam int         WDTU_SEL_LSB     = 4;
    localparam int         WDTU_SEL_W       = 4;

    // Values after reset
    localparam logic [3:0] WDTU_SEL_RST     = 4'h7;
    localparam logic       WDTU_ARM_RST     = 1'b1;
    localparam logic       WDTU_RESP_RST    = 1'b0;
    localparam logic       WDTU_STATUS_RST  = 1'b0;

    // Timeout select codes
    localparam logic [3:0] WDTU_SEL_MAX     = 4'h7;
    localparam logic [3:0] WDTU_SEL_AUTO    = 4'h8;
    localparam logic [3:0] WDTU_SEL_DLOAD   = 4'h9;

    // Crystal timing: shortest period is 2^9 crystal ticks (15.6 ms)
    localparam int         WDTU_XTAL_HZ     = 32768;
    localparam int         WDTU_CNT_W       = 16;
    localparam int         WDTU_BASE_SHIFT  = 9;
    localparam logic [15:0] WDTU_CNT_FULL   = 16'hFFFF;

    // Progress of the two-step write unlock
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_SET  = 2'b01,
        UL_OPEN = 2'b10
    } wdtu_unlock_t;

endpackage

// [hdl/wdtu_unit.sv]
// Watchdog timer unit: control register, unlock sequencing, timeout counter.
// Assumes a core-side SFR port with byte and bit writes, an end-of-instruction
// pulse, and a one-cycle crystal tick enable at 32.768 kHz, all on clk.
module wdtu_unit
    import wdtu_pkg::*;
(
    // Clock and pin reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Byte access to special-function registers
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    // Single-bit writes (bit address space)
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wr,
    input  wire logic       bit_wdata,
    // Core timing
    input  wire logic       insn_end,
    input  wire logic       xtal_tick,
    // Flash byte, most significant bit
    input  wire logic       flash_lock_bit,
    // Requests to reset generator and interrupt controller
    output logic            wdt_sys_reset_req,
    output logic            wdt_download_req,
    output logic            wdt_irq_req
);
    import wdtu_pkg::*;

    logic [3:0]            sel_q;
    logic                  resp_q;
    logic                  arm_q;
    logic                  status_q;
    logic [WDTU_CNT_W-1:0] cnt_q;
    wdtu_unlock_t          ul_q;
    wdtu_unlock_t          ul_d;
    logic [3:0]            sel_d;
    logic                  status_d;
    logic [WDTU_CNT_W-1:0] cnt_d;
    logic [7:0]            rdata_q;
    logic                  sysrst_q;
    logic                  dload_q;
    logic                  irq_q;

    logic                  locked;
    logic                  arm_eff;
    logic                  resp_eff;
    logic [7:0]            cur_val;
    logic                  byte_hit;
    logic                  bit_hit;
    logic                  wr_any;
    logic [7:0]            new_val;
    logic                  accept;
    logic                  unlock_req;
    logic [3:0]            new_sel;
    logic                  auto_rst;
    logic                  dload_rst;
    logic                  sel_valid;
    logic [WDTU_CNT_W-1:0] code_limit [8];
    logic [WDTU_CNT_W-1:0] limit;
    logic                  expire;
    logic                  own_rst;
    logic                  restart;

    // Flash lock is active while the stored bit reads zero
    assign locked   = ~flash_lock_bit;
    assign arm_eff  = arm_q | locked;
    assign resp_eff = resp_q & ~locked;

    // Register image as software sees it
    always_comb begin
        cur_val                  = 8'h00;
        cur_val[WDTU_SEL_LSB+:4] = sel_q;
        cur_val[WDTU_RESP_BIT]   = resp_eff;
        cur_val[WDTU_STATUS_BIT] = status_q;
        cur_val[WDTU_ARM_BIT]    = arm_eff;
        cur_val[WDTU_UNLOCK_BIT] = (ul_q != UL_IDLE);
    end

    // Bit addresses C0..C7 reach control bits 0..7
    assign byte_hit = sfr_wr && (sfr_addr == WDTU_CTRL_ADDR);
    assign bit_hit  = bit_wr && (bit_addr[7:3] == WDTU_CTRL_ADDR[7:3]);
    assign wr_any   = byte_hit || bit_hit;

    // Bit writes merge into the current image; the unlock bit of the
    // image is not carried, so a bit write elsewhere cannot re-unlock.
    always_comb begin
        if (byte_hit) begin
            new_val = sfr_wdata;
        end else begin
            new_val = cur_val;
            new_val[WDTU_UNLOCK_BIT] = 1'b0;
            new_val[bit_addr[2:0]]   = bit_wdata;
        end
    end

    // The honoured write consumes the unlock; otherwise setting bit 0 unlocks
    assign accept     = wr_any && (ul_q == UL_OPEN);
    assign unlock_req = wr_any && !accept && new_val[WDTU_UNLOCK_BIT];
    assign new_sel    = new_val[WDTU_SEL_LSB+:4];

    // Zero-delay resets selected by special codes
    assign auto_rst  = accept && (new_sel == WDTU_SEL_AUTO);
    assign dload_rst = accept && (new_sel == WDTU_SEL_DLOAD);

    // Period doubles per code: code 0 is 512 ticks, code 7 is 65536
    assign sel_valid = (sel_q <= WDTU_SEL_MAX);
    for (genvar g = 0; g <= int'(WDTU_SEL_MAX); g++) begin : g_limit
        assign code_limit[g] = WDTU_CNT_FULL >> (int'(WDTU_SEL_MAX) - g);
    end
    assign limit     = code_limit[sel_q[2:0]];
    assign expire    = arm_eff && xtal_tick && sel_valid
                       && (cnt_q == limit);

    // Watchdog reset re-initialises this unit, except the status flag
    assign own_rst = (expire && !resp_eff) || auto_rst || dload_rst;
    assign restart = accept && new_val[WDTU_ARM_BIT];

    // Unlock sequencing: set during one instruction, open for the next
    always_comb begin
        ul_d = ul_q;
        unique case (ul_q)
            UL_IDLE: begin
                if (unlock_req) begin
                    ul_d = insn_end ? UL_OPEN : UL_SET;
                end
            end
            UL_SET: begin
                if (insn_end) begin
                    ul_d = UL_OPEN;
                end
            end
            UL_OPEN: begin
                if (accept || insn_end) begin
                    ul_d = UL_IDLE;
                end
            end
            default: begin
                ul_d = UL_IDLE;
            end
        endcase
        if (own_rst) begin
            ul_d = UL_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ul_q <= UL_IDLE;
        end else begin
            ul_q <= ul_d;
        end
    end

    // Timeout select: writable even under flash lock
    // Codes 1000 and 1001 never persist: they re-initialise the unit at once
    always_comb begin
        sel_d = sel_q;
        if (own_rst) begin
            sel_d = WDTU_SEL_RST;
        end else if (accept) begin
            sel_d = new_sel;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= WDTU_SEL_RST;
        end else begin
            sel_q <= sel_d;
        end
    end

    // Arm and response: frozen while the flash lock is active
    // Under lock the stored bits keep their value; the image is forced instead
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arm_q <= WDTU_ARM_RST;
        end else if (own_rst) begin
            arm_q <= WDTU_ARM_RST;
        end else if (accept && !locked) begin
            arm_q <= new_val[WDTU_ARM_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp_q <= WDTU_RESP_RST;
        end else if (own_rst) begin
            resp_q <= WDTU_RESP_RST;
        end else if (accept && !locked) begin
            resp_q <= new_val[WDTU_RESP_BIT];
        end
    end

    // Status survives own resets; only pin reset or a written zero clear it.
    // A timeout in the same cycle as the clearing write wins.
    always_comb begin
        status_d = status_q;
        if (accept && !new_val[WDTU_STATUS_BIT]) begin
            status_d = 1'b0;
        end
        if (expire) begin
            status_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= WDTU_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Counter advances on crystal ticks only, so periods ignore clk rate
    // Held, not cleared, while disarmed; re-arming, expiry or own reset zeroes it
    always_comb begin
        cnt_d = cnt_q;
        if (own_rst || restart) begin
            cnt_d = '0;
        end else if (expire) begin
            cnt_d = '0;
        end else if (arm_eff && xtal_tick) begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Response requests, one cycle each
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sysrst_q <= 1'b0;
        end else begin
            sysrst_q <= (expire && !resp_eff) || auto_rst;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dload_q <= 1'b0;
        end else begin
            dload_q <= dload_rst;
        end
    end

    // No global enable gating: this request always goes out.
    // A reset issued in the same cycle takes precedence over it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= expire && resp_eff && !auto_rst && !dload_rst;
        end
    end

    // Registered read data; other addresses read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            rdata_q <= (sfr_addr == WDTU_CTRL_ADDR) ? cur_val : 8'h00;
        end
    end

    assign sfr_rdata         = rdata_q;
    assign wdt_sys_reset_req = sysrst_q;
    assign wdt_download_req  = dload_q;
    assign wdt_irq_req       = irq_q;

endmodule

// [dv/wdtu_properties.sv]
// Port-level checks for the watchdog timer unit.
// Assumes binding onto wdtu_unit; one clock domain.
module wdtu_properties
    import wdtu_pkg::*;
(
    // Ports of the unit used by the checks; write data, bit address, bit data and insn_end are not taken
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       bit_wr,
    input wire logic       xtal_tick,
    input wire logic       flash_lock_bit,
    input wire logic       wdt_sys_reset_req,
    input wire logic       wdt_download_req,
    input wire logic       wdt_irq_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_rd_zero; sfr_rd && sfr_addr != WDTU_CTRL_ADDR |=> sfr_rdata == 8'h00; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("other address read not zero");
    property p_lock_image; sfr_rd && sfr_addr == WDTU_CTRL_ADDR && !flash_lock_bit |=> !sfr_rdata[3] && sfr_rdata[1]; endproperty
    a_lock_image: assert property (p_lock_image) else $error("locked image wrong");
    property p_sys_pulse; wdt_sys_reset_req |=> !wdt_sys_reset_req; endproperty
    a_sys_pulse: assert property (p_sys_pulse) else $error("reset request too long");
    property p_irq_pulse; wdt_irq_req |=> !wdt_irq_req; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt request too long");
    property p_dl_pulse; wdt_download_req |=> !wdt_download_req; endproperty
    a_dl_pulse: assert property (p_dl_pulse) else $error("download request too long");
    property p_one_resp; !(wdt_sys_reset_req && wdt_irq_req); endproperty
    a_one_resp: assert property (p_one_resp) else $error("reset and interrupt together");
    property p_irq_tick; wdt_irq_req |-> $past(xtal_tick); endproperty
    a_irq_tick: assert property (p_irq_tick) else $error("interrupt without crystal tick");
    property p_dl_write; wdt_download_req |-> $past(sfr_wr || bit_wr); endproperty
    a_dl_write: assert property (p_dl_write) else $error("download request without write");
    property p_sys_cause; wdt_sys_reset_req |-> $past(xtal_tick || sfr_wr || bit_wr); endproperty
    a_sys_cause: assert property (p_sys_cause) else $error("reset request without cause");
endmodule

// [dv/wdtu_unit_tb.sv]
// Self-checking bench for the watchdog timer unit through its SFR port.
// Assumes every cycle ends an instruction unless stalled; ticks may run each clk.
module wdtu_unit_tb
    import wdtu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, resetn = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 0;
    logic       insn_end = 1, xtal_tick = 0, flash_lock_bit = 1;
    logic [7:0] sfr_addr = 8'hC0, sfr_wdata = 8'h00, bit_addr = 8'hC0, sfr_rdata;
    logic       wdt_sys_reset_req, wdt_download_req, wdt_irq_req;
    int         failures = 0, check_count = 0, nsys = 0, ndl = 0, nirq = 0, cyc = 0;

    wdtu_unit i_dut (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .bit_addr,
        .bit_wr, .bit_wdata, .insn_end, .xtal_tick, .flash_lock_bit, .wdt_sys_reset_req,
        .wdt_download_req, .wdt_irq_req);

    always #25 clk = ~clk;

    // Bounds the run well past the longest timeout
    always @(posedge clk) begin
        cyc++;
        nsys += (wdt_sys_reset_req === 1'b1);
        ndl += (wdt_download_req === 1'b1);
        nirq += (wdt_irq_req === 1'b1);
        if (cyc == 80000) begin
            failures++;
            results();
        end
    end

    task results;
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task ticks(input int n);
        xtal_tick = 1;
        idle(n);
        xtal_tick = 0;
    endtask
    task rd(input logic [7:0] exp);
        sfr_rd = 1;
        idle(1);
        sfr_rd = 0;
        chk(sfr_rdata, exp);
    endtask
    task unlock;
        bit_wdata = 1;
        bit_wr = 1;
        idle(1);
        bit_wr = 0;
    endtask
    task wr(input logic [7:0] d);
        sfr_wdata = d;
        sfr_wr = 1;
        idle(1);
        sfr_wr = 0;
    endtask
    task uwr(input logic [7:0] d);
        unlock();
        wr(d);
    endtask
    // Unlock, then a single-bit write; the strobe stays up between the two
    task ubit(input logic [7:0] a, input logic v);
        bit_wdata = 1;
        bit_wr = 1;
        idle(1);
        bit_addr = a;
        bit_wdata = v;
        idle(1);
        bit_wr = 0;
        bit_addr = 8'hC0;
    endtask

    initial begin
        idle(10);
        resetn = 1;
        rd(8'h72);
        ticks(65535);
        chk(nsys, 0);
        idle(1);
        ticks(1);
        idle(2);
        chk(nsys, 1);
        rd(8'h76);
        uwr(8'h02);
        rd(8'h02);
        ticks(511);
        chk(nsys, 1);
        idle(1);
        ticks(1);
        idle(2);
        chk(nsys, 2);
        uwr(8'h0A);
        ticks(300);
        uwr(8'h0A);
        ticks(511);
        chk(nirq, 0);
        idle(1);
        ticks(1);
        idle(2);
        chk(nirq, 1);
        chk(nsys, 2);
        rd(8'h0E);
        uwr(8'h08);
        ticks(600);
        chk(nirq, 1);
        wr(8'h02);
        rd(8'h08);
        unlock();
        idle(1);
        wr(8'h02);
        rd(8'h08);
        insn_end = 0;
        unlock();
        idle(3);
        insn_end = 1;
        idle(1);
        wr(8'h0A);
        rd(8'h0A);
        uwr(8'h0E);
        rd(8'h0A);
        ubit(8'hC1, 1'b0);
        rd(8'h08);
        idle(1);
        sfr_addr = 8'h55;
        rd(8'h00);
        sfr_addr = 8'hC0;
        idle(1);
        flash_lock_bit = 0;
        rd(8'h02);
        uwr(8'h38);
        rd(8'h32);
        flash_lock_bit = 1;
        uwr(8'h80);
        idle(2);
        chk(nsys, 3);
        uwr(8'h90);
        idle(2);
        chk(ndl, 1);
        uwr(8'h02);
        ticks(512);
        idle(2);
        chk(nsys, 4);
        rd(8'h76);
        resetn = 0;
        idle(2);
        chk(sfr_rdata, 8'h00);
        resetn = 1;
        rd(8'h72);
        results();
    end
endmodule

bind wdtu_unit wdtu_properties i_props (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_rdata, .bit_wr,
    .xtal_tick, .flash_lock_bit, .wdt_sys_reset_req, .wdt_download_req, .wdt_irq_req);
